// ### src/sre_pkg.sv
/*
 * Constants for the security page erase block: opcodes, address
 * fields, status bit positions, register offsets and erase timing.
 * Assumes a 125 MHz pclk and a single serial host on the flash pins.
 */
package sre_pkg;

	// ********************************
	// Serial command set
	// ********************************
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h44;
	localparam logic [5:0] OPCODE_BITS = 6'h08;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam logic [5:0] BIT_COUNT_MAX = 6'h3F;

	// ********************************
	// Address fields and page storage
	// ********************************
	localparam logic [7:0] ADDR_TOP_VALUE = 8'h00;
	localparam logic [3:0] ADDR_MID_VALUE = 4'h0;
	localparam logic [3:0] PAGE1_CODE = 4'h1;
	localparam logic [3:0] PAGE3_CODE = 4'h3;
	localparam int PAGE_BYTES = 256;
	localparam int PAGE_COUNT = 3;
	localparam int MEM_BYTES = PAGE_BYTES * PAGE_COUNT;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ********************************
	// Status byte and interrupt bits
	// ********************************
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LATCH_BIT = 1;
	localparam int IRQ_ERASE_DONE = 0;
	localparam int IRQ_CMD_DROPPED = 1;
	localparam int IRQ_WIDTH = 2;

	// ********************************
	// APB register offsets
	// ********************************
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_LOCK = 12'h004;
	localparam logic [11:0] REG_IRQ_STATUS = 12'h008;
	localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
	localparam logic [11:0] REG_MEM_ADDR = 12'h010;
	localparam logic [11:0] REG_MEM_DATA = 12'h014;

	// ********************************
	// Erase timing
	// ********************************
	localparam int PAGE_ERASE_TIME_US = 100000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int PAGE_ERASE_CYCLES = (PAGE_ERASE_TIME_US * 1000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_READY = 2'b01,
		ST_ERASE = 2'b10
	} sre_state_e;

endpackage : sre_pkg

// ### src/sre_erase_top.sv
/*
 * Security page erase engine: serial command front end sampled by
 * pclk, three 256-byte pages, self-timed erase, APB register slave.
 * Assumes the serial clock is slow enough (80 ns period) for pclk
 * to see every level through a three-stage filter.
 */
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Three separate erasable 256-byte security pages
// - Erase accepted only while write latch set
// - Address bits 15:12 pick page 1-3
// - Select rising mid-byte discards the command
// - Select rise starts timed page erase
// - Status read still answered during erase
// - Busy high whole erase, erase and write enable refused meanwhile
// - Erase completion clears write latch flag
// - Locked page ignores erase commands until reset
// - Erased bytes read FFh, program only erased
module sre_erase_top #(
	parameter int ERASE_CYCLES = sre_pkg::PAGE_ERASE_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial flash pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_oe,
	// Interrupt
	output logic irq
);

	// ********************************
	// Pin synchronisers and filters
	// ********************************
	logic [2:0] cs_sync_ff, nxt_cs_sync;
	logic [2:0] sclk_sync_ff, nxt_sclk_sync;
	logic [2:0] din_sync_ff, nxt_din_sync;
	logic cs_f_ff, nxt_cs_f, sclk_f_ff, nxt_sclk_f, din_f_ff, nxt_din_f;
	logic cs_q_ff, sclk_q_ff;
	logic cs_rise, cs_fall, sclk_rise, sclk_fall;

	// Level accepted only when the last two stages agree
	always_comb
	begin
		nxt_cs_sync = {cs_sync_ff[1:0], spi_cs_n};
		nxt_sclk_sync = {sclk_sync_ff[1:0], spi_sclk};
		nxt_din_sync = {din_sync_ff[1:0], serial_in_pin};
		nxt_cs_f = (cs_sync_ff[1] == cs_sync_ff[2]) ? cs_sync_ff[2] : cs_f_ff;
		nxt_sclk_f = (sclk_sync_ff[1] == sclk_sync_ff[2]) ? sclk_sync_ff[2] : sclk_f_ff;
		nxt_din_f = (din_sync_ff[1] == din_sync_ff[2]) ? din_sync_ff[2] : din_f_ff;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cs_sync_ff <= 3'h7;
			sclk_sync_ff <= 3'h0;
			din_sync_ff <= 3'h0;
			cs_f_ff <= 1'b1;
			sclk_f_ff <= 1'b0;
			din_f_ff <= 1'b0;
			cs_q_ff <= 1'b1;
			sclk_q_ff <= 1'b0;
		end
		else
		begin
			cs_sync_ff <= nxt_cs_sync;
			sclk_sync_ff <= nxt_sclk_sync;
			din_sync_ff <= nxt_din_sync;
			cs_f_ff <= nxt_cs_f;
			sclk_f_ff <= nxt_sclk_f;
			din_f_ff <= nxt_din_f;
			cs_q_ff <= cs_f_ff;
			sclk_q_ff <= sclk_f_ff;
		end
	end

	// Edges of the filtered levels
	assign cs_rise = cs_f_ff & ~cs_q_ff;
	assign cs_fall = ~cs_f_ff & cs_q_ff;
	assign sclk_rise = sclk_f_ff & ~sclk_q_ff & ~cs_f_ff;
	assign sclk_fall = ~sclk_f_ff & sclk_q_ff & ~cs_f_ff;

	// ********************************
	// Command shifter and decode
	// ********************************
	logic [31:0] shift_ff, nxt_shift;
	logic [5:0] bitcnt_ff, nxt_bitcnt;
	logic [7:0] opcode_ff, nxt_opcode;
	logic [2:0] out_idx_ff, nxt_out_idx;
	logic serial_out_ff, nxt_serial_out;
	logic [1:0] page_idx;
	logic page_ok, page_locked, erase_frame, erase_start, cmd_drop, latch_set;
	sre_pkg::sre_state_e state_ff, nxt_state;
	logic write_latch_ff, nxt_write_latch;
	logic [3:1] lock_ff, nxt_lock;
	logic busy;
	logic [7:0] status_byte;

	assign busy = (state_ff == sre_pkg::ST_ERASE);
	assign status_byte = {6'h00, write_latch_ff, busy};

	// Page pick from the 24 address bits held in the low shifter bits
	always_comb
	begin
		page_ok = (shift_ff[23:16] == sre_pkg::ADDR_TOP_VALUE)
			&& (shift_ff[11:8] == sre_pkg::ADDR_MID_VALUE)
			&& (shift_ff[15:12] >= sre_pkg::PAGE1_CODE)
			&& (shift_ff[15:12] <= sre_pkg::PAGE3_CODE);
		page_idx = shift_ff[13:12] - 2'h1;
		page_locked = lock_ff[page_idx + 2'h1];
	end

	// Frame-end decisions; busy refuses every new erase or write enable
	always_comb
	begin
		erase_frame = cs_rise && !busy && (opcode_ff == sre_pkg::OP_PAGE_ERASE);
		erase_start = erase_frame && (bitcnt_ff == sre_pkg::FRAME_BITS) && write_latch_ff
			&& page_ok && !page_locked;
		cmd_drop = erase_frame && !erase_start;
		latch_set = cs_rise && !busy && (opcode_ff == sre_pkg::OP_WRITE_ENABLE)
			&& (bitcnt_ff == sre_pkg::OPCODE_BITS);
	end

	// Shift in MSB first on rising serial clock, status out on falling
	always_comb
	begin
		nxt_shift = shift_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_opcode = opcode_ff;
		nxt_out_idx = out_idx_ff;
		nxt_serial_out = serial_out_ff;
		if (cs_fall)
		begin
			nxt_bitcnt = 6'h00;
			nxt_opcode = 8'h00;
			nxt_out_idx = 3'h0;
		end
		else if (sclk_rise)
		begin
			nxt_shift = {shift_ff[30:0], din_f_ff};
			if (bitcnt_ff != sre_pkg::BIT_COUNT_MAX)
				nxt_bitcnt = bitcnt_ff + 6'h01;
			if (bitcnt_ff == sre_pkg::OPCODE_BITS - 6'h01)
				nxt_opcode = {shift_ff[6:0], din_f_ff};
		end
		else if (sclk_fall && (bitcnt_ff >= sre_pkg::OPCODE_BITS)
			&& (opcode_ff == sre_pkg::OP_READ_STATUS))
		begin
			nxt_serial_out = status_byte[3'h7 - out_idx_ff];
			nxt_out_idx = out_idx_ff + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shift_ff <= 32'h0000_0000;
			bitcnt_ff <= 6'h00;
			opcode_ff <= 8'h00;
			out_idx_ff <= 3'h0;
			serial_out_ff <= 1'b0;
		end
		else
		begin
			shift_ff <= nxt_shift;
			bitcnt_ff <= nxt_bitcnt;
			opcode_ff <= nxt_opcode;
			out_idx_ff <= nxt_out_idx;
			serial_out_ff <= nxt_serial_out;
		end
	end

	// Status byte repeats for as long as select stays low
	assign serial_out_pin = serial_out_ff;
	assign serial_out_oe = ~cs_f_ff && (opcode_ff == sre_pkg::OP_READ_STATUS)
		&& (bitcnt_ff >= sre_pkg::OPCODE_BITS);

	// ********************************
	// Erase engine and page storage
	// ********************************
	logic [7:0] mem [0:sre_pkg::MEM_BYTES-1];
	logic [1:0] erase_page_ff, nxt_erase_page;
	logic [8:0] erase_ptr_ff, nxt_erase_ptr;
	logic [31:0] erase_cnt_ff, nxt_erase_cnt;
	logic erase_done;
	logic mem_we;
	logic [9:0] mem_wa;
	logic [7:0] mem_wd;
	logic [9:0] mem_addr_ff, nxt_mem_addr;
	logic [7:0] mem_rd;
	logic apb_wr, apb_rd_setup;
	logic [1:0] irq_st_ff, nxt_irq_st, irq_mask_ff, nxt_irq_mask;
	logic [31:0] prdata_ff, nxt_prdata;
	logic addr_hit;

	assign erase_done = busy && (erase_cnt_ff == 32'(ERASE_CYCLES - 1));

	// Sequencer; the timer, not the fill, sets the erase length
	always_comb
	begin
		nxt_state = state_ff;
		nxt_erase_page = erase_page_ff;
		nxt_erase_ptr = erase_ptr_ff;
		nxt_erase_cnt = erase_cnt_ff;
		nxt_write_latch = write_latch_ff;
		unique case (state_ff)
			sre_pkg::ST_READY:
			begin
				if (latch_set)
					nxt_write_latch = 1'b1;
				if (erase_start)
				begin
					nxt_state = sre_pkg::ST_ERASE;
					nxt_erase_page = page_idx;
					nxt_erase_ptr = 9'h000;
					nxt_erase_cnt = 32'h0000_0000;
				end
			end
			sre_pkg::ST_ERASE:
			begin
				nxt_erase_cnt = erase_cnt_ff + 32'h0000_0001;
				if (!erase_ptr_ff[8])
					nxt_erase_ptr = erase_ptr_ff + 9'h001;
				if (erase_done)
				begin
					nxt_state = sre_pkg::ST_READY;
					nxt_write_latch = 1'b0;
				end
			end
			default:
				nxt_state = sre_pkg::ST_READY;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= sre_pkg::ST_READY;
			erase_page_ff <= 2'h0;
			erase_ptr_ff <= 9'h000;
			erase_cnt_ff <= 32'h0000_0000;
			write_latch_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			erase_page_ff <= nxt_erase_page;
			erase_ptr_ff <= nxt_erase_ptr;
			erase_cnt_ff <= nxt_erase_cnt;
			write_latch_ff <= nxt_write_latch;
		end
	end

	// Single write port: erase fill, else an APB program of an erased byte
	always_comb
	begin
		mem_rd = (mem_addr_ff[9:8] == 2'h3) ? sre_pkg::ERASED_BYTE : mem[mem_addr_ff];
		mem_we = 1'b0;
		mem_wa = {erase_page_ff, erase_ptr_ff[7:0]};
		mem_wd = sre_pkg::ERASED_BYTE;
		if (busy && !erase_ptr_ff[8])
			mem_we = 1'b1;
		else if (!busy && apb_wr && (paddr == sre_pkg::REG_MEM_DATA)
			&& (mem_addr_ff[9:8] != 2'h3) && (mem_rd == sre_pkg::ERASED_BYTE))
		begin
			mem_we = 1'b1;
			mem_wa = mem_addr_ff;
			mem_wd = pwdata[7:0];
		end
	end

	// Storage array has no reset, like the cells it stands for
	always_ff @(posedge pclk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	// ********************************
	// APB slave, lock bits, interrupts
	// ********************************
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd_setup = psel && !penable && !pwrite;
	assign addr_hit = (paddr == sre_pkg::REG_STATUS) || (paddr == sre_pkg::REG_LOCK)
		|| (paddr == sre_pkg::REG_IRQ_STATUS) || (paddr == sre_pkg::REG_IRQ_MASK)
		|| (paddr == sre_pkg::REG_MEM_ADDR) || (paddr == sre_pkg::REG_MEM_DATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata = prdata_ff;
	assign irq = |(irq_st_ff & irq_mask_ff);

	// Register writes; lock bits only ever set; event set beats clear
	always_comb
	begin
		nxt_lock = lock_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_mem_addr = mem_addr_ff;
		nxt_irq_st = irq_st_ff;
		nxt_prdata = prdata_ff;
		if (apb_wr && (paddr == sre_pkg::REG_LOCK))
			nxt_lock = lock_ff | pwdata[3:1];
		if (apb_wr && (paddr == sre_pkg::REG_IRQ_MASK))
			nxt_irq_mask = pwdata[sre_pkg::IRQ_WIDTH-1:0];
		if (apb_wr && (paddr == sre_pkg::REG_MEM_ADDR))
			nxt_mem_addr = pwdata[9:0];
		if (apb_wr && (paddr == sre_pkg::REG_IRQ_STATUS))
			nxt_irq_st = irq_st_ff & ~pwdata[sre_pkg::IRQ_WIDTH-1:0];
		if (erase_done)
			nxt_irq_st[sre_pkg::IRQ_ERASE_DONE] = 1'b1;
		if (cmd_drop)
			nxt_irq_st[sre_pkg::IRQ_CMD_DROPPED] = 1'b1;
		if (apb_rd_setup)
		begin
			unique case (paddr)
				sre_pkg::REG_STATUS:
					nxt_prdata = {24'h000000, status_byte};
				sre_pkg::REG_LOCK:
					nxt_prdata = {28'h0000000, lock_ff, 1'b0};
				sre_pkg::REG_IRQ_STATUS:
					nxt_prdata = {30'h00000000, irq_st_ff};
				sre_pkg::REG_IRQ_MASK:
					nxt_prdata = {30'h00000000, irq_mask_ff};
				sre_pkg::REG_MEM_ADDR:
					nxt_prdata = {22'h000000, mem_addr_ff};
				sre_pkg::REG_MEM_DATA:
					nxt_prdata = {24'h000000, mem_rd};
				default:
					nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_ff <= 3'h0;
			irq_mask_ff <= 2'h0;
			mem_addr_ff <= 10'h000;
			irq_st_ff <= 2'h0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			lock_ff <= nxt_lock;
			irq_mask_ff <= nxt_irq_mask;
			mem_addr_ff <= nxt_mem_addr;
			irq_st_ff <= nxt_irq_st;
			prdata_ff <= nxt_prdata;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	a_erase_needs_latch: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(busy) |-> $past(write_latch_ff))
		else $error("erase began without write latch");
	a_erase_full_frame: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(busy) |-> $past(cs_rise) && ($past(bitcnt_ff) == sre_pkg::FRAME_BITS))
		else $error("erase began without a full 32-bit frame");
	a_busy_holds: assert property (@(posedge pclk) disable iff (!presetn)
		busy && cs_rise && !erase_done |=> busy && (erase_cnt_ff != 32'h0000_0000))
		else $error("frame end during erase disturbed the erase");
	a_latch_cleared: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) |-> !write_latch_ff && irq_st_ff[sre_pkg::IRQ_ERASE_DONE])
		else $error("write latch not cleared at erase end");
	a_locked_page_kept: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(busy) |-> !lock_ff[erase_page_ff + 2'h1])
		else $error("erase started on a locked page");
	a_page_erased_ff: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) |-> mem[{erase_page_ff, 8'hFF}] == sre_pkg::ERASED_BYTE)
		else $error("page not erased to FFh");
	a_bad_addr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		erase_frame && !page_ok |=> !busy && (write_latch_ff == $past(write_latch_ff)))
		else $error("bad address changed busy or write latch");
	a_status_busy_bit: assert property (@(posedge pclk) disable iff (!presetn)
		busy && sclk_fall && serial_out_oe && (out_idx_ff == 3'h7) |=> serial_out_pin)
		else $error("status read lost busy during erase");

endmodule : sre_erase_top

`default_nettype wire

// ### tb/sre_host_model.sv
/* Host serial controller model: drives select, link clock and data in.
   Assumes the device samples these pins with its own faster clock. */
`timescale 1ns/1ps
`default_nettype none
module sre_host_model (
	// Flash pins
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic serial_in_pin,
	input wire logic serial_out_pin
);
	// ********************
	// Frame driver
	// ********************
	// Idle: deselected, link clock parked low between frames
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		serial_in_pin = 1'b1;
	end

	// Send d[n-1:0] MSB first; sample the reply late in each high phase
	task automatic xfer(input int n, input logic [31:0] d, output logic [7:0] rd);
		rd = 8'h00;
		#3 spi_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_in_pin = d[i];
			#40 spi_sclk = 1'b1;
			#39 rd = {rd[6:0], serial_out_pin};
			#1 spi_sclk = 1'b0;
		end
		// Select rises only once the last bit was latched
		#40 spi_cs_n = 1'b1;
		serial_in_pin = ~serial_in_pin; // No stale bit on a released line
		#77;
	endtask : xfer
endmodule : sre_host_model
`default_nettype wire

// ### tb/tb_top.sv
/* Self-checking bench for the security page erase block.
   Assumes the host model owns the flash pins; APB is driven here. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ********************
	// Signals and helpers
	// ********************
	// Short erase so several full erases fit the run
	localparam int ERASE = 300;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, spi_cs_n, spi_sclk, serial_in_pin, serial_out_pin, serial_out_oe, irq;
	logic perr;
	logic [7:0] sb, lo;
	logic [7:0] pa [1:3];
	logic [7:0] pb [1:3];
	logic [31:0] bad [3] = '{32'h44004000, 32'h44001800, 32'h44011000};
	int err_total = 0, comparisons = 0, seed = 53694, n, el;
	time t0;

	// Free-running system clock
	always #4 pclk = ~pclk;

	sre_erase_top #(.ERASE_CYCLES(ERASE)) dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin),
		.serial_out_oe(serial_out_oe),
		.irq(irq)
	);
	sre_host_model host (.spi_cs_n, .spi_sclk, .serial_in_pin, .serial_out_pin);

	// Erase frame: opcode, page address with a free low byte
	function automatic logic [31:0] frame(input logic [3:0] p, input logic [7:0] b);
		return {sre_pkg::OP_PAGE_ERASE, sre_pkg::ADDR_TOP_VALUE, p, sre_pkg::ADDR_MID_VALUE, b};
	endfunction : frame

	// Verdict; a wait that ran out counts as a mismatch
	task automatic wrap_up(input bit hang);
		if (hang)
			err_total++;
		$display("Checks %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			k++;
			if (k > 8)
				wrap_up(1'b1);
			@(posedge pclk);
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk

	// Serial frame through the host, then back onto a pclk edge
	task automatic ser(input int nb, input logic [31:0] d);
		host.xfer(nb, d, sb);
		@(posedge pclk);
	endtask : ser

	// ********************
	// Scenarios
	// ********************
	initial #400000 wrap_up(1'b1);

	// Main sequence
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(sre_pkg::REG_STATUS, 32'h0);
		rchk(sre_pkg::REG_LOCK, 32'h0);
		apb(1'b0, 12'h018, 32'h1);
		chk({rd[30:0], perr}, 32'h1);
		lo = 8'($random(seed));
		ser(32, frame(4'h1, lo));
		rchk(sre_pkg::REG_STATUS, 32'h0);
		rchk(sre_pkg::REG_IRQ_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, sre_pkg::REG_IRQ_MASK, 32'h3);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, sre_pkg::REG_IRQ_STATUS, 32'h3);
		chk({31'h0, irq}, 32'h0);
		// Each page: enable, erase, poll, read back erased, program once
		for (int p = 1; p <= 3; p++)
		begin
			pa[p] = 8'($random(seed));
			pb[p] = 8'($random(seed)) & 8'h7F;
			ser(8, 32'h06);
			// Output enable seen high mid-reply, low once select is back up
			fork
				ser(16, 32'h0500);
				begin
					#1002;
					chk({31'h0, serial_out_oe}, 32'h1);
				end
			join
			chk({24'h0, sb}, 32'h2);
			chk({31'h0, serial_out_oe}, 32'h0);
			ser(32, frame(4'(p), pa[p]));
			t0 = $time;
			ser(16, 32'h0500);
			chk({24'h0, sb}, 32'h3);
			rd = 32'h1;
			n = 0;
			while (rd[0] !== 1'b0)
			begin
				apb(1'b0, sre_pkg::REG_STATUS, 32'h0);
				n++;
				if (n > 300)
					wrap_up(1'b1);
			end
			el = int'(($time - t0) / 8);
			chk({31'h0, el > ERASE - 20 && el < ERASE + 10}, 32'h1);
			rchk(sre_pkg::REG_STATUS, 32'h0);
			rchk(sre_pkg::REG_IRQ_STATUS, 32'h1);
			chk({31'h0, irq}, 32'h1);
			apb(1'b1, sre_pkg::REG_IRQ_STATUS, 32'h1);
			apb(1'b1, sre_pkg::REG_MEM_ADDR, {22'h0, 2'(p - 1), pa[p]});
			rchk(sre_pkg::REG_MEM_DATA, 32'hFF);
			apb(1'b1, sre_pkg::REG_MEM_DATA, {24'h0, pb[p]});
			apb(1'b1, sre_pkg::REG_MEM_DATA, {24'h0, ~pb[p]});
			rchk(sre_pkg::REG_MEM_DATA, {24'h0, pb[p]});
		end
		// Later erases left the first page alone
		apb(1'b1, sre_pkg::REG_MEM_ADDR, {24'h0, pa[1]});
		rchk(sre_pkg::REG_MEM_DATA, {24'h0, pb[1]});
		// Select raised one bit early drops the frame
		ser(8, 32'h06);
		ser(31, frame(4'h1, lo) >> 1);
		apb(1'b0, sre_pkg::REG_STATUS, 32'h0);
		chk({31'h0, rd[0]}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, sre_pkg::REG_IRQ_MASK, 32'h1);
		chk({31'h0, irq}, 32'h0);
		// Addresses outside the three pages leave status alone
		ser(8, 32'h06);
		foreach (bad[i])
		begin
			ser(32, bad[i]);
			rchk(sre_pkg::REG_STATUS, 32'h2);
		end
		// A locked page stays locked and keeps its data
		apb(1'b1, sre_pkg::REG_LOCK, 32'h4);
		apb(1'b1, sre_pkg::REG_LOCK, 32'h0);
		rchk(sre_pkg::REG_LOCK, 32'h4);
		ser(32, frame(4'h2, lo));
		apb(1'b0, sre_pkg::REG_STATUS, 32'h0);
		chk({31'h0, rd[0]}, 32'h0);
		apb(1'b1, sre_pkg::REG_MEM_ADDR, {22'h0, 2'h1, pa[2]});
		rchk(sre_pkg::REG_MEM_DATA, {24'h0, pb[2]});
		wrap_up(1'b0);
	end
endmodule : tb_top
`default_nettype wire
